// ===== twb_ctrl.sv
module twb_ctrl
	import twb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic global_irq_en,
	output logic irq,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	logic rst_meta_reg, rst_n;
	logic [7:0] rate_reg, addr_reg, data_reg, status_reg, rdata_reg, end_code;
	logic [1:0] ps_reg, phase_reg;
	logic done_reg, acken_reg, sta_reg, sto_reg, wc_reg, en_reg, ie_reg, go_reg;
	logic done_evt_reg, sto_clr_reg, busy_reg, scl_q_reg, sda_q_reg;
	logic scl_oe_reg, sda_oe_reg, cond_stop_reg, master_reg, tx_reg, addr_ph_reg;
	logic rw_reg, gc_reg, addressed_reg, acked_reg, ackbit_reg, lost_reg;
	logic [3:0] cnt_reg;
	twb_state_t state_reg;
	logic wr_ctrl, wr_data, launch, half_tick, scl_rise, scl_fall;
	logic start_det, stop_det, shift_en, own_hit, gc_hit;

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// decode and line events
	assign wr_ctrl = io_wr && io_addr == OFS_CTRL;
	assign wr_data = io_wr && io_addr == OFS_DATA;
	assign launch = wr_ctrl && io_wdata[BIT_DONE] && done_reg;
	assign scl_rise = scl_in && !scl_q_reg;
	assign scl_fall = !scl_in && scl_q_reg;
	assign start_det = scl_in && scl_q_reg && sda_q_reg && !sda_in;
	assign stop_det = scl_in && scl_q_reg && !sda_q_reg && sda_in;
	assign shift_en = en_reg && state_reg == S_BIT && scl_rise && cnt_reg != ACK_SLOT;
	// own address and general call comparator
	assign own_hit = data_reg[7:1] == addr_reg[7:1];
	assign gc_hit = data_reg[7:1] == 7'h00 && addr_reg[0];
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;
	assign io_rdata = rdata_reg;
	assign irq = done_reg && ie_reg && global_irq_en;

	twb_rate_gen u_rate (
		.clk(clk),
		.rst_n(rst_n),
		.run(en_reg && (state_reg == S_COND || (state_reg == S_BIT && master_reg))),
		.divider(rate_reg),
		.prescale(ps_reg),
		.half_tick(half_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus_control bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
			acken_reg <= 1'b0;
			sta_reg <= 1'b0;
			sto_reg <= 1'b0;
			en_reg <= 1'b0;
			ie_reg <= 1'b0;
			wc_reg <= 1'b0;
			go_reg <= 1'b0;
		end else begin
			// hardware set wins over a software clear
			if (done_evt_reg)
				done_reg <= 1'b1;
			else if (wr_ctrl && io_wdata[BIT_DONE])
				done_reg <= 1'b0;
			// clearing the flag launches the engine
			go_reg <= launch;
			if (wr_ctrl) begin
				acken_reg <= io_wdata[BIT_ACKEN];
				sta_reg <= io_wdata[BIT_STA];
				en_reg <= io_wdata[BIT_EN];
				ie_reg <= io_wdata[BIT_IE];
			end
			// stop bit cleared once the stop is done
			if (wr_ctrl)
				sto_reg <= io_wdata[BIT_STO];
			else if (sto_clr_reg)
				sto_reg <= 1'b0;
			// collision on write while flag low
			if (wr_data)
				wc_reg <= !done_reg;
		end
	end

	// rate, prescale and own address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_reg <= RST_RATE;
			ps_reg <= RST_STAT[1:0];
			addr_reg <= RST_ADDR;
		end else if (io_wr) begin
			if (io_addr == OFS_RATE)
				rate_reg <= io_wdata;
			if (io_addr == OFS_STAT)
				ps_reg <= io_wdata[1:0];
			if (io_addr == OFS_ADDR)
				addr_reg <= io_wdata;
		end
	end

	// data byte doubles as the shifter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			data_reg <= RST_DATA;
		else if (wr_data && done_reg)
			data_reg <= io_wdata;
		else if (shift_en)
			data_reg <= {data_reg[6:0], sda_in};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
				OFS_RATE: rdata_reg <= rate_reg;
				OFS_STAT: rdata_reg <= {done_reg ? status_reg[7:3] : RST_STAT[7:3], 1'b0, ps_reg};
				OFS_ADDR: rdata_reg <= addr_reg;
				OFS_DATA: rdata_reg <= data_reg;
				OFS_CTRL: rdata_reg <= {done_reg, acken_reg, sta_reg, sto_reg, wc_reg, en_reg,
					1'b0, ie_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// line history and bus busy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			busy_reg <= 1'b0;
		end else begin
			scl_q_reg <= scl_in;
			sda_q_reg <= sda_in;
			if (!en_reg || stop_det)
				busy_reg <= 1'b0;
			else if (start_det)
				busy_reg <= 1'b1;
		end
	end

	// status code at the end of a byte
	always_comb begin
		if (lost_reg && !addressed_reg)
			end_code = ST_ARB_LOST;
		else if (master_reg && addr_ph_reg)
			end_code = rw_reg ? (ackbit_reg ? ST_SLAR_NACK : ST_SLAR_ACK)
				: (ackbit_reg ? ST_SLAW_NACK : ST_SLAW_ACK);
		else if (master_reg)
			end_code = tx_reg ? (ackbit_reg ? ST_MT_NACK : ST_MT_ACK)
				: (acked_reg ? ST_MR_ACK : ST_MR_NACK);
		else if (addr_ph_reg)
			end_code = gc_reg ? ST_SR_GC : (rw_reg ? ST_ST_SLA : ST_SR_SLA);
		else if (tx_reg)
			end_code = ackbit_reg ? ST_ST_NACK : ST_ST_ACK;
		else if (gc_reg)
			end_code = acked_reg ? ST_GC_ACK : ST_GC_NACK;
		else
			end_code = acked_reg ? ST_SR_ACK : ST_SR_NACK;
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			status_reg <= RST_STAT;
			phase_reg <= 2'd0;
			cnt_reg <= 4'h0;
			{scl_oe_reg, sda_oe_reg, cond_stop_reg, master_reg, tx_reg} <= 5'h00;
			{addr_ph_reg, rw_reg, gc_reg, addressed_reg, acked_reg} <= 5'h00;
			{ackbit_reg, lost_reg, done_evt_reg, sto_clr_reg} <= 4'h0;
		end else begin
			done_evt_reg <= 1'b0;
			sto_clr_reg <= 1'b0;
			if (!en_reg) begin
				state_reg <= S_IDLE;
				scl_oe_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
				master_reg <= 1'b0;
				addressed_reg <= 1'b0;
			end else begin
				case (state_reg)
					S_IDLE: begin
						if (start_det) begin
							state_reg <= S_BIT;
							cnt_reg <= 4'h0;
							{addr_ph_reg, tx_reg, lost_reg} <= 3'b100;
						// start once the bus is free
						end else if (sta_reg && !busy_reg && !done_reg) begin
							state_reg <= S_COND;
							cond_stop_reg <= 1'b0;
							phase_reg <= 2'd2;
						end
					end
					S_COND: begin
						// 0 set sda, 1 free scl, 2 move sda with scl high, 3 finish
						if (half_tick && !(phase_reg == 2'd2 && !scl_in)) begin
							phase_reg <= phase_reg + 2'd1;
							case (phase_reg)
								2'd0: sda_oe_reg <= cond_stop_reg;
								2'd1: scl_oe_reg <= 1'b0;
								2'd2: sda_oe_reg <= !cond_stop_reg;
								default: begin
									if (cond_stop_reg) begin
										state_reg <= S_IDLE;
										master_reg <= 1'b0;
										sto_clr_reg <= 1'b1;
									end else begin
										scl_oe_reg <= 1'b1;
										state_reg <= S_WAIT;
										done_evt_reg <= 1'b1;
										status_reg <= master_reg ? ST_RSTART : ST_START;
										master_reg <= 1'b1;
									end
								end
							endcase
						end
					end
					S_WAIT: begin
						if (go_reg) begin
							lost_reg <= 1'b0;
							if (sta_reg && (master_reg || !busy_reg)) begin
								state_reg <= S_COND;
								cond_stop_reg <= 1'b0;
								phase_reg <= 2'd0;
							end else if (sto_reg && master_reg) begin
								state_reg <= S_COND;
								cond_stop_reg <= 1'b1;
								phase_reg <= 2'd0;
							end else if (!sta_reg && !sto_reg && (master_reg || addressed_reg)) begin
								state_reg <= S_BIT;
								cnt_reg <= 4'h0;
								addr_ph_reg <= master_reg && (status_reg == ST_START
									|| status_reg == ST_RSTART);
								if (master_reg && (status_reg == ST_START
									|| status_reg == ST_RSTART || !rw_reg)) begin
									tx_reg <= 1'b1;
									sda_oe_reg <= !data_reg[7];
								end else begin
									tx_reg <= !master_reg && rw_reg;
									sda_oe_reg <= !master_reg && rw_reg && !data_reg[7];
								end
								if (!master_reg)
									scl_oe_reg <= 1'b0;
							end else begin
								// recover to unaddressed slave, no stop sent
								state_reg <= S_IDLE;
								scl_oe_reg <= 1'b0;
								sda_oe_reg <= 1'b0;
								addressed_reg <= 1'b0;
								sto_clr_reg <= sto_reg;
							end
						end
					end
					S_BIT: begin
						if ((start_det || stop_det) && cnt_reg != 4'h0) begin
							// misplaced condition is a bus error
							state_reg <= S_WAIT;
							status_reg <= ST_BUSERR;
							done_evt_reg <= 1'b1;
							{scl_oe_reg, sda_oe_reg, master_reg, addressed_reg} <= 4'h0;
						end else if (start_det) begin
							cnt_reg <= 4'h0;
							{addr_ph_reg, tx_reg, master_reg, sda_oe_reg} <= 4'b1000;
						end else if (stop_det) begin
							state_reg <= S_IDLE;
							{addressed_reg, master_reg, sda_oe_reg} <= 3'b000;
						end else begin
							// master clocks the bit, waits out a stretched low
							if (master_reg && half_tick) begin
								if (scl_oe_reg)
									scl_oe_reg <= 1'b0;
								else if (scl_in)
									scl_oe_reg <= 1'b1;
							end
							if (scl_rise) begin
								if (cnt_reg == ACK_SLOT)
									ackbit_reg <= sda_in;
								// lost arbitration, keep receiving as slave
								else if (tx_reg && master_reg && !sda_oe_reg && !sda_in) begin
									{lost_reg, master_reg, tx_reg} <= 3'b100;
								end
							end
							if (scl_fall) begin
								cnt_reg <= cnt_reg + 4'h1;
								if (cnt_reg == 4'h7) begin
									if (addr_ph_reg && master_reg) begin
										rw_reg <= data_reg[0];
										sda_oe_reg <= 1'b0;
									end else if (addr_ph_reg) begin
										// answer own address or general call
										if (acken_reg && (own_hit || gc_hit)) begin
											{sda_oe_reg, addressed_reg, acked_reg} <= 3'b111;
											gc_reg <= gc_hit;
											rw_reg <= data_reg[0];
										end else begin
											{sda_oe_reg, acked_reg} <= 2'b00;
											if (!lost_reg)
												state_reg <= S_IDLE;
										end
									end else if (tx_reg) begin
										sda_oe_reg <= 1'b0;
									end else begin
										sda_oe_reg <= acken_reg;
										acked_reg <= acken_reg;
									end
								end else if (cnt_reg == ACK_SLOT) begin
									state_reg <= S_WAIT;
									scl_oe_reg <= 1'b1;
									sda_oe_reg <= 1'b0;
									done_evt_reg <= 1'b1;
									status_reg <= end_code;
									if (!master_reg && tx_reg && ackbit_reg)
										addressed_reg <= 1'b0;
								end else begin
									sda_oe_reg <= tx_reg && !data_reg[7];
								end
							end
						end
					end
					default: state_reg <= S_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_scl_stretch: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == S_WAIT && done_reg && (master_reg || addressed_reg)) |-> scl_oe_reg)
		else $error("scl released while job done flag set");
	a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(done_reg && !(wr_ctrl && io_wdata[BIT_DONE])) |=> done_reg)
		else $error("job done flag cleared without software");
	a_launch_next: assert property (@(posedge clk) disable iff (!rst_n)
		(launch && en_reg && state_reg == S_WAIT && !done_evt_reg) |-> ##2 state_reg != S_WAIT)
		else $error("launch did not leave wait");
	a_collision_set: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_data && !done_reg) |=> (wc_reg && data_reg == ($past(shift_en)
		? {$past(data_reg[6:0]), $past(sda_in)} : $past(data_reg))))
		else $error("write collision missed");
	a_start_kept: assert property (@(posedge clk) disable iff (!rst_n)
		(sta_reg && !wr_ctrl) |=> sta_reg)
		else $error("start request cleared by hardware");
	a_enable_abort: assert property (@(posedge clk) disable iff (!rst_n)
		!en_reg |=> (state_reg == S_IDLE && !scl_oe_reg && !sda_oe_reg))
		else $error("disable did not abort");
	a_idle_status: assert property (@(posedge clk) disable iff (!rst_n)
		(io_rd && io_addr == OFS_STAT && !done_reg) |=> io_rdata[7:3] == RST_STAT[7:3])
		else $error("status not 0xf8 while flag clear");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		irq == (done_reg && ie_reg && global_irq_en))
		else $error("irq not raised with flag");
	a_stop_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == S_COND && cond_stop_reg && phase_reg == 2'd3 && half_tick && !wr_ctrl)
		|=> ##1 !sto_reg)
		else $error("stop request not cleared");
endmodule : twb_ctrl

// ===== twb_pkg.sv
package twb_pkg;
	// register offsets
	localparam logic [5:0] OFS_RATE = 6'h00;
	localparam logic [5:0] OFS_STAT = 6'h01;
	localparam logic [5:0] OFS_ADDR = 6'h02;
	localparam logic [5:0] OFS_DATA = 6'h03;
	localparam logic [5:0] OFS_CTRL = 6'h36;
	// bus_control field positions
	localparam int BIT_DONE = 7;
	localparam int BIT_ACKEN = 6;
	localparam int BIT_STA = 5;
	localparam int BIT_STO = 4;
	localparam int BIT_WC = 3;
	localparam int BIT_EN = 2;
	localparam int BIT_IE = 0;
	// values after reset
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_STAT = 8'hf8;
	localparam logic [7:0] RST_ADDR = 8'h7f;
	localparam logic [7:0] RST_DATA = 8'hff;
	// half an SCL period is this plus divider times prescale factor
	localparam logic [15:0] HALF_BASE = 16'h0008;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// status codes
	localparam logic [7:0] ST_BUSERR = 8'h00;
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_SLAW_ACK = 8'h18;
	localparam logic [7:0] ST_SLAW_NACK = 8'h20;
	localparam logic [7:0] ST_MT_ACK = 8'h28;
	localparam logic [7:0] ST_MT_NACK = 8'h30;
	localparam logic [7:0] ST_ARB_LOST = 8'h38;
	localparam logic [7:0] ST_SLAR_ACK = 8'h40;
	localparam logic [7:0] ST_SLAR_NACK = 8'h48;
	localparam logic [7:0] ST_MR_ACK = 8'h50;
	localparam logic [7:0] ST_MR_NACK = 8'h58;
	localparam logic [7:0] ST_SR_SLA = 8'h60;
	localparam logic [7:0] ST_SR_GC = 8'h70;
	localparam logic [7:0] ST_SR_ACK = 8'h80;
	localparam logic [7:0] ST_SR_NACK = 8'h88;
	localparam logic [7:0] ST_GC_ACK = 8'h90;
	localparam logic [7:0] ST_GC_NACK = 8'h98;
	localparam logic [7:0] ST_ST_SLA = 8'ha8;
	localparam logic [7:0] ST_ST_ACK = 8'hb8;
	localparam logic [7:0] ST_ST_NACK = 8'hc0;
	typedef enum logic [1:0] {S_IDLE, S_COND, S_BIT, S_WAIT} twb_state_t;
endpackage : twb_pkg

// ===== twb_rate_gen.sv
module twb_rate_gen
	import twb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [7:0] divider,
	input wire logic [1:0] prescale,
	output logic half_tick
);
	logic [15:0] count_reg;

	// half period in clocks, prescale factor 1, 4, 16, 64
	function automatic logic [15:0] half_len(input logic [7:0] div, input logic [1:0] ps);
		half_len = HALF_BASE + ({8'h00, div} << {ps, 1'b0});
	endfunction : half_len

	// reload divider, one pulse per half period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= HALF_BASE;
			half_tick <= 1'b0;
		end else if (!run || count_reg <= 16'h0001) begin
			count_reg <= half_len(divider, prescale);
			half_tick <= run;
		end else begin
			count_reg <= count_reg - 16'h0001;
			half_tick <= 1'b0;
		end
	end
endmodule : twb_rate_gen

// ===== twb_bus_model.sv
////////////////////////////////////////////////////////////////////////////////
// far-side slave: acks its own address and every data byte, can stretch scl
module twb_bus_model #(
	parameter logic [6:0] DEV_ADDR = 7'h3a
) (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] stretch,
	output logic scl_oe,
	output logic sda_oe,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic in_frame = 1'b0;
	logic is_addr = 1'b0;
	logic [7:0] sh = 8'h00;
	// lines released at time zero
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		rx_byte = 8'h00;
	end
	// start: sda falls while scl high
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			cnt = 0;
			in_frame = 1'b1;
			is_addr = 1'b1;
		end
	end
	// stop: sda rises while scl high, leave the frame and let go of sda
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			in_frame = 1'b0;
			sda_oe <= 1'b0;
		end
	end
	// shift one bit in on each rising scl, msb first
	always @(posedge scl) begin
		if (in_frame && cnt < 8) begin
			sh = {sh[6:0], sda};
			cnt = cnt + 1;
		end
	end
	// ack slot: pull sda, optionally hold scl low on the address byte
	always @(negedge scl) begin
		if (in_frame && cnt == 8) begin
			cnt = 9;
			if (!is_addr)
				rx_byte <= sh;
			if (!is_addr || sh[7:1] == DEV_ADDR)
				sda_oe <= 1'b1;
			if (is_addr && stretch != 8'h00) begin
				scl_oe <= 1'b1;
				repeat (stretch) @(posedge clk);
				scl_oe <= 1'b0;
			end
		end else if (in_frame && cnt == 9) begin
			sda_oe <= 1'b0;
			cnt = 0;
			is_addr = 1'b0;
		end
	end
endmodule : twb_bus_model

// ===== two_wire_bus_ctrl_regs_tb.sv
module two_wire_bus_ctrl_regs_tb
	import twb_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] PEER = 7'h3a; // arbitrary peer address
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] io_addr = 6'h00;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic global_irq_en = 1'b0;
	logic [7:0] io_rdata, rx_byte, rd;
	logic irq, scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
	logic [7:0] stretch = 8'h00;
	logic scl_q = 1'b1;
	wire scl_line = ~(scl_oe | m_scl_oe);
	wire sda_line = ~(sda_oe | m_sda_oe);
	int miscompares = 0;
	int compares = 0;
	int seed = 32'hc904;
	int cnt_since = 0;
	int last_per = 0;
	int exp_rate = 0;
	int exp_ps = 0;
	int sent_q[$];
	logic [5:0] ofs_tab[6] = '{OFS_RATE, OFS_STAT, OFS_ADDR, OFS_DATA, OFS_CTRL, 6'h10};
	logic [7:0] rst_tab[6] = '{8'h00, 8'hf8, 8'h7f, 8'hff, 8'h00, 8'h00};
	////////////////////////////////////////////////////////////////////////////
	// clock
	always #5 clk = ~clk;
	// clocks between two rising scl edges
	always @(posedge clk) begin
		scl_q <= scl_line;
		cnt_since <= (scl_line && !scl_q) ? 1 : cnt_since + 1;
		if (scl_line && !scl_q)
			last_per <= cnt_since;
	end
	twb_ctrl dut (.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.global_irq_en(global_irq_en), .irq(irq), .scl_in(scl_line), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
	twb_bus_model #(.DEV_ADDR(PEER)) peer (.clk(clk), .scl(scl_line), .sda(sda_line),
		.stretch(stretch), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte(rx_byte));
	////////////////////////////////////////////////////////////////////////////
	// verdict
	task automatic stop_test();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	// byte compare
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	// pin compare
	task automatic chk_pin(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pin
	// register write, one strobe cycle
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		io_wr <= 1'b1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask : wr
	// register read, data taken once it has landed
	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		io_rd <= 1'b1;
		io_addr <= a;
		@(posedge clk);
		io_rd <= 1'b0;
		@(posedge clk);
		#1 d = io_rdata;
	endtask : rd_reg
	// poll a control bit, bounded
	task automatic wait_ctrl(input int b, input logic v);
		int n;
		n = 0;
		rd_reg(OFS_CTRL, rd);
		while (rd[b] !== v && n < 3000) begin
			rd_reg(OFS_CTRL, rd);
			n++;
		end
		if (rd[b] !== v) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, rd[b], v);
			stop_test();
		end
	endtask : wait_ctrl
	// status compare with prescaler bits merged in
	task automatic chk_status(input logic [7:0] code);
		rd_reg(OFS_STAT, rd);
		chk_reg(rd, code | 8'(exp_ps));
	endtask : chk_status
	// start, address, one data byte if acked, stop
	task automatic xfer(input logic [6:0] sla, input logic [7:0] d);
		wr(OFS_CTRL, 8'ha5);
		wait_ctrl(7, 1'b1);
		chk_status(ST_START);
		chk_pin(irq, global_irq_en);
		repeat (20) @(posedge clk);
		chk_pin(scl_oe, 1'b1);
		chk_pin(scl_out | sda_out, 1'b0);
		wr(OFS_DATA, {sla, 1'b0});
		rd_reg(OFS_CTRL, rd);
		chk_reg(rd, 8'ha5);
		// data loaded, start bit dropped, then launch
		wr(OFS_CTRL, 8'h85);
		wait_ctrl(7, 1'b1);
		chk_status((sla == PEER) ? ST_SLAW_ACK : ST_SLAW_NACK);
		if (sla == PEER) begin
			sent_q.push_back(d);
			wr(OFS_DATA, d);
			wr(OFS_CTRL, 8'h85);
			wait_ctrl(7, 1'b1);
			chk_status(ST_MT_ACK);
			rd_reg(OFS_DATA, rd);
			chk_reg(rd, d);
			chk_reg(rx_byte, 8'(sent_q.pop_front()));
			chk_reg(8'(last_per), 8'(16 + 2 * exp_rate * (4 ** exp_ps)));
		end
		wr(OFS_CTRL, 8'h95);
		wait_ctrl(4, 1'b0);
		chk_status(8'hf8);
		chk_pin(sda_oe | scl_oe, 1'b0);
	endtask : xfer
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] d;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rd_reg(ofs_tab[i], rd);
			chk_reg(rd, rst_tab[i]);
		end
		$display("test 1 done");
		d = 8'($random(seed));
		wr(OFS_ADDR, d);
		rd_reg(OFS_ADDR, rd);
		chk_reg(rd, d);
		d = 8'($random(seed));
		exp_ps = d[1:0];
		wr(OFS_STAT, d);
		rd_reg(OFS_STAT, rd);
		chk_reg(rd, 8'hf8 | 8'(exp_ps));
		$display("test 2 done");
		wr(OFS_DATA, 8'h5a);
		rd_reg(OFS_CTRL, rd);
		chk_reg(rd, 8'h08);
		rd_reg(OFS_DATA, rd);
		chk_reg(rd, 8'hff);
		$display("test 3 done");
		for (int p = 0; p < 4; p++) begin
			exp_rate = (p == 0) ? 3 : 1;
			exp_ps = p;
			wr(OFS_RATE, 8'(exp_rate));
			wr(OFS_STAT, 8'(p));
			global_irq_en <= p[0];
			stretch <= (p == 2) ? 8'h28 : 8'h00;
			xfer(PEER, 8'($random(seed)));
			$display("test 4 prescale %0d done", p);
		end
		xfer(PEER ^ 7'h01, 8'h00);
		$display("test 5 done");
		wr(OFS_CTRL, 8'ha5);
		wait_ctrl(7, 1'b1);
		wr(OFS_DATA, {PEER, 1'b0});
		wr(OFS_CTRL, 8'h85);
		repeat (60) @(posedge clk);
		wr(OFS_CTRL, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk_pin(scl_oe | sda_oe, 1'b0);
		chk_pin(irq, 1'b0);
		rd_reg(OFS_CTRL, rd);
		chk_reg(rd, 8'h00);
		$display("test 6 done");
		stop_test();
	end
endmodule : two_wire_bus_ctrl_regs_tb
